// >>> hw/mcl_top.v
// Purpose: Control word, limit registers, start and power-down selection, averaging and alert detection.
// Assumes: Register port and all pins synchronous to ref_clk_i.
// Notes: Results arrive per sample; samples of one input arrive back to back.
`timescale 1ns/1ps
`default_nettype none
`include "mcl_consts.vh"

module mcl_top #(
  parameter SQ100_HALF_CYCLES = `MCL_SQ100_HALF_US * `MCL_CLK_MHZ,
  parameter SQ1K_HALF_CYCLES = `MCL_SQ1K_HALF_US * `MCL_CLK_MHZ
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [11:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire conv_trigger_n_i,
  input wire cs_n_i,
  input wire power_down_pin_n_i,
  input wire result_valid_i,
  input wire [3:0] result_chan_i,
  input wire [11:0] result_data_i,
  input wire alert_chain_i,
  output reg conv_start_o,
  output reg [1:0] conv_set_o,
  output reg [1:0] read_set_o,
  output reg power_down_o,
  output reg soft_reset_o,
  output reg [5:0] acq_cycles_o,
  output reg thermistor_termination_pin_o,
  output reg [11:0] fault_flags_o,
  output reg alert_o
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function [11:0] scale_limit;
    input [7:0] thr;
    input [31:0] offset_mv;
    input [31:0] step_mv;
    reg [31:0] code;
    begin
      code = ((offset_mv + step_mv * thr) * 32'd4096) / `MCL_FULL_SCALE_MV;
      scale_limit = (code > 32'd4095) ? 12'hFFF : code[11:0];
    end
  endfunction

  function [5:0] ns_to_cycles;
    input [31:0] ns;
    reg [31:0] c;
    begin
      c = (ns + `MCL_CLK_PERIOD_NS - 1) / `MCL_CLK_PERIOD_NS;
      ns_to_cycles = c[5:0];
    end
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  reg [15:0] ctrl;
  reg [7:0] volt_high;
  reg [7:0] volt_low;
  reg [7:0] temp_high;
  reg [7:0] temp_low;
  reg [7:0] alert_cfg;
  reg trig_prev;
  reg cs_prev;
  reg pd_prev;
  reg pd_latched;
  reg rd_pend;
  reg [5:0] rd_addr_q;

  wire sreset = ctrl[`MCL_SOFT_RST];
  wire [11:0] mem_rdata;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= `MCL_CTRL_RESET;
      volt_high <= `MCL_VOLT_HIGH_RESET;
      volt_low <= `MCL_VOLT_LOW_RESET;
      temp_high <= `MCL_TEMP_HIGH_RESET;
      temp_low <= `MCL_TEMP_LOW_RESET;
      alert_cfg <= `MCL_ALERT_CFG_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `MCL_ADDR_CTRL_UPPER: ctrl[15:8] <= reg_wdata_i;
        `MCL_ADDR_CTRL_LOWER: ctrl[7:0] <= reg_wdata_i;
        `MCL_ADDR_VOLT_HIGH: volt_high <= reg_wdata_i;
        `MCL_ADDR_VOLT_LOW: volt_low <= reg_wdata_i;
        `MCL_ADDR_TEMP_HIGH: temp_high <= reg_wdata_i;
        `MCL_ADDR_TEMP_LOW: temp_low <= reg_wdata_i;
        `MCL_ADDR_ALERT_CFG: alert_cfg <= reg_wdata_i;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Reads answer two cycles after the request; result addresses go through the memory.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pend <= 1'b0;
      rd_addr_q <= 6'h00;
      reg_rvalid_o <= 1'b0;
      reg_rdata_o <= 12'h000;
    end else begin
      rd_pend <= reg_rd_i;
      if (reg_rd_i) begin
        rd_addr_q <= reg_addr_i;
      end
      reg_rvalid_o <= rd_pend;
      if (rd_pend) begin
        case (rd_addr_q)
          `MCL_ADDR_CTRL_UPPER: reg_rdata_o <= {4'h0, ctrl[15:8]};
          `MCL_ADDR_CTRL_LOWER: reg_rdata_o <= {4'h0, ctrl[7:0]};
          `MCL_ADDR_VOLT_HIGH: reg_rdata_o <= {4'h0, volt_high};
          `MCL_ADDR_VOLT_LOW: reg_rdata_o <= {4'h0, volt_low};
          `MCL_ADDR_TEMP_HIGH: reg_rdata_o <= {4'h0, temp_high};
          `MCL_ADDR_TEMP_LOW: reg_rdata_o <= {4'h0, temp_low};
          `MCL_ADDR_ALERT_CFG: reg_rdata_o <= {4'h0, alert_cfg};
          default: reg_rdata_o <= (rd_addr_q <= `MCL_ADDR_LAST_RESULT) ? mem_rdata : 12'h000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Control outputs
  // ------------------------------------------------------------------
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_prev <= 1'b1;
      cs_prev <= 1'b1;
      pd_prev <= 1'b1;
      pd_latched <= 1'b0;
      conv_start_o <= 1'b0;
      conv_set_o <= 2'h0;
      read_set_o <= 2'h0;
      power_down_o <= 1'b0;
      soft_reset_o <= 1'b0;
      acq_cycles_o <= 6'h00;
      thermistor_termination_pin_o <= 1'b0;
    end else begin
      trig_prev <= conv_trigger_n_i;
      cs_prev <= cs_n_i;
      pd_prev <= power_down_pin_n_i;
      if (ctrl[`MCL_START_SRC]) begin
        conv_start_o <= !sreset && !cs_prev && cs_n_i;
      end else begin
        conv_start_o <= !sreset && trig_prev && !conv_trigger_n_i;
      end
      conv_set_o <= ctrl[`MCL_CONV_SET_HI:`MCL_CONV_SET_LO];
      read_set_o <= ctrl[`MCL_READ_SET_HI:`MCL_READ_SET_LO];
      if (pd_prev && !power_down_pin_n_i) begin
        pd_latched <= 1'b1;
      end else if (power_down_pin_n_i) begin
        pd_latched <= 1'b0;
      end
      power_down_o <= ctrl[`MCL_PD_SRC] ? 1'b1 : pd_latched;
      soft_reset_o <= sreset;
      case (ctrl[`MCL_ACQ_HI:`MCL_ACQ_LO])
        2'h0: acq_cycles_o <= ns_to_cycles(`MCL_ACQ0_NS);
        2'h1: acq_cycles_o <= ns_to_cycles(`MCL_ACQ1_NS);
        2'h2: acq_cycles_o <= ns_to_cycles(`MCL_ACQ2_NS);
        default: acq_cycles_o <= ns_to_cycles(`MCL_ACQ3_NS);
      endcase
      thermistor_termination_pin_o <= ctrl[`MCL_THERM_TERM];
    end
  end

  // ------------------------------------------------------------------
  // Averaging
  // ------------------------------------------------------------------
  reg [14:0] acc;
  reg [3:0] avg_cnt;
  reg [3:0] avg_chan;
  reg store_en;
  reg [3:0] store_chan;
  reg [11:0] store_data;
  reg [3:0] avg_need;
  reg [1:0] avg_shift;
  reg [14:0] next_acc;
  reg [14:0] avg_val;

  always @* begin
    case (ctrl[`MCL_AVG_HI:`MCL_AVG_LO])
      2'h0: avg_need = 4'h1;
      2'h1: avg_need = 4'h2;
      2'h2: avg_need = 4'h4;
      default: avg_need = 4'h8;
    endcase
    avg_shift = ctrl[`MCL_AVG_HI:`MCL_AVG_LO];
    if (avg_cnt == 4'h0 || result_chan_i != avg_chan) begin
      next_acc = {3'h0, result_data_i};
    end else begin
      next_acc = acc + {3'h0, result_data_i};
    end
    avg_val = next_acc >> avg_shift;
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc <= 15'h0000;
      avg_cnt <= 4'h0;
      avg_chan <= 4'h0;
      store_en <= 1'b0;
      store_chan <= 4'h0;
      store_data <= 12'h000;
    end else if (sreset) begin
      avg_cnt <= 4'h0;
      store_en <= 1'b0;
    end else begin
      store_en <= 1'b0;
      if (result_valid_i) begin
        avg_chan <= result_chan_i;
        acc <= next_acc;
        if (((result_chan_i != avg_chan) ? 4'h1 : avg_cnt + 4'h1) >= avg_need) begin
          avg_cnt <= 4'h0;
          store_en <= 1'b1;
          store_chan <= result_chan_i;
          store_data <= avg_val[11:0];
        end else begin
          avg_cnt <= (result_chan_i != avg_chan) ? 4'h1 : avg_cnt + 4'h1;
        end
      end
    end
  end

  mcl_result_mem i_mcl_result_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(store_en),
    .wr_addr_i(store_chan),
    .wr_data_i(store_data),
    .rd_addr_i(reg_addr_i[3:0]),
    .rd_data_o(mem_rdata)
  );

  // ------------------------------------------------------------------
  // Limit detection and alert
  // ------------------------------------------------------------------
  reg [11:0] include_mask;
  reg [17:0] sq_cnt;
  reg sq_wave;
  wire any_fault = |fault_flags_o;

  always @* begin
    include_mask = 12'hFFF;
    case (alert_cfg[3:2])
      2'h1: include_mask[4] = 1'b0;
      2'h2: include_mask[4:3] = 2'h0;
      default: include_mask[4] = 1'b1;
    endcase
    case (alert_cfg[1:0])
      2'h1: include_mask[10] = 1'b0;
      2'h2: include_mask = include_mask & 12'hAFF;
      default: include_mask[10] = 1'b1;
    endcase
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_flags_o <= 12'h000;
    end else if (sreset) begin
      fault_flags_o <= 12'h000;
    end else begin
      fault_flags_o <= fault_flags_o & include_mask;
      if (store_en && store_chan < 4'h6 && include_mask[store_chan]) begin
        fault_flags_o[store_chan] <=
          (store_data > scale_limit(volt_high, `MCL_VOLT_OFFSET_MV, `MCL_VOLT_STEP_MV)) ||
          (store_data < scale_limit(volt_low, `MCL_VOLT_OFFSET_MV, `MCL_VOLT_STEP_MV));
      end else if (store_en && store_chan < 4'hC && include_mask[store_chan]) begin
        fault_flags_o[store_chan] <=
          (store_data > scale_limit(temp_high, `MCL_TEMP_OFFSET_MV, `MCL_TEMP_STEP_MV)) ||
          (store_data < scale_limit(temp_low, `MCL_TEMP_OFFSET_MV, `MCL_TEMP_STEP_MV));
      end
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sq_cnt <= 18'h00000;
      sq_wave <= 1'b0;
      alert_o <= 1'b0;
    end else begin
      if (sq_cnt >= ((alert_cfg[`MCL_ALERT_FREQ_HI:`MCL_ALERT_FREQ_LO] == `MCL_ALERT_FREQ_1KHZ) ?
                     SQ1K_HALF_CYCLES[17:0] - 18'h1 : SQ100_HALF_CYCLES[17:0] - 18'h1)) begin
        sq_cnt <= 18'h00000;
        sq_wave <= !sq_wave;
      end else begin
        sq_cnt <= sq_cnt + 18'h1;
      end
      case (alert_cfg[`MCL_ALERT_MODE_HI:`MCL_ALERT_MODE_LO])
        `MCL_ALERT_MODE_STATIC: alert_o <= any_fault;
        `MCL_ALERT_MODE_SQUARE: alert_o <= any_fault && sq_wave &&
                                           !alert_cfg[`MCL_ALERT_FREQ_HI];
        `MCL_ALERT_MODE_PASS: alert_o <= alert_chain_i && !any_fault;
        default: alert_o <= 1'b0;
      endcase
    end
  end

endmodule // mcl_top

`default_nettype wire

// >>> hw/mcl_consts.vh
// Purpose: Shared offsets, field positions, reset values and timing counts of the monitor control bank.
// Assumes: 25 MHz system clock.
// Notes: Header holds definitions only.
`ifndef MCL_CONSTS_VH
`define MCL_CONSTS_VH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define MCL_ADDR_LAST_RESULT 6'h0C
`define MCL_ADDR_CTRL_UPPER 6'h0D
`define MCL_ADDR_CTRL_LOWER 6'h0E
`define MCL_ADDR_VOLT_HIGH 6'h0F
`define MCL_ADDR_VOLT_LOW 6'h10
`define MCL_ADDR_TEMP_HIGH 6'h11
`define MCL_ADDR_TEMP_LOW 6'h12
`define MCL_ADDR_ALERT_CFG 6'h13

// ------------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------------
`define MCL_CONV_SET_HI 15
`define MCL_CONV_SET_LO 14
`define MCL_READ_SET_HI 13
`define MCL_READ_SET_LO 12
`define MCL_START_SRC 11
`define MCL_AVG_HI 10
`define MCL_AVG_LO 9
`define MCL_PD_SRC 8
`define MCL_SOFT_RST 7
`define MCL_ACQ_HI 6
`define MCL_ACQ_LO 5
`define MCL_THERM_TERM 3

// ------------------------------------------------------------------
// Alert configuration fields
// ------------------------------------------------------------------
`define MCL_ALERT_MODE_HI 7
`define MCL_ALERT_MODE_LO 6
`define MCL_ALERT_FREQ_HI 5
`define MCL_ALERT_FREQ_LO 4
`define MCL_ALERT_MODE_OFF 2'h0
`define MCL_ALERT_MODE_STATIC 2'h1
`define MCL_ALERT_MODE_SQUARE 2'h2
`define MCL_ALERT_MODE_PASS 2'h3
`define MCL_ALERT_FREQ_100HZ 2'h0
`define MCL_ALERT_FREQ_1KHZ 2'h1

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define MCL_CTRL_RESET 16'h0000
`define MCL_VOLT_HIGH_RESET 8'hFF
`define MCL_VOLT_LOW_RESET 8'h00
`define MCL_TEMP_HIGH_RESET 8'hFF
`define MCL_TEMP_LOW_RESET 8'h00
`define MCL_ALERT_CFG_RESET 8'h00

// ------------------------------------------------------------------
// Threshold scaling, millivolts
// ------------------------------------------------------------------
`define MCL_FULL_SCALE_MV 5000
`define MCL_VOLT_OFFSET_MV 1000
`define MCL_VOLT_STEP_MV 16
`define MCL_TEMP_OFFSET_MV 0
`define MCL_TEMP_STEP_MV 19

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define MCL_CLK_PERIOD_NS 40
`define MCL_CLK_MHZ 25
`define MCL_ACQ0_NS 400
`define MCL_ACQ1_NS 800
`define MCL_ACQ2_NS 1200
`define MCL_ACQ3_NS 1600
`define MCL_SQ100_HALF_US 5000
`define MCL_SQ1K_HALF_US 500

`endif

// >>> hw/mcl_result_mem.v
// Purpose: Storage of sixteen 12-bit conversion results.
// Assumes: One write and one read port on the same clock.
// Notes: Read data is registered, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module mcl_result_mem (
  input wire ref_clk_i,
  input wire wr_en_i,
  input wire [3:0] wr_addr_i,
  input wire [11:0] wr_data_i,
  input wire [3:0] rd_addr_i,
  output reg [11:0] rd_data_o
);

  reg [11:0] store [0:15];

  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      store[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= store[rd_addr_i];
  end

endmodule // mcl_result_mem

`default_nettype wire

// >>> tb/mcl_top_props.sv
// Purpose: Port assertions for the monitor control bank.
// Assumes: Bound to mcl_top; one clock domain.
// Notes: Latencies follow the hand-over contract.
`timescale 1ns/1ps
`default_nettype none
module mcl_top_props (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  input wire logic conv_trigger_n_i,
  input wire logic cs_n_i,
  input wire logic power_down_pin_n_i,
  input wire logic result_valid_i,
  input wire logic conv_start_o,
  input wire logic [1:0] conv_set_o,
  input wire logic [1:0] read_set_o,
  input wire logic power_down_o,
  input wire logic soft_reset_o,
  input wire logic [5:0] acq_cycles_o,
  input wire logic [11:0] fault_flags_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_read_answer: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
    else $error("read answer missing");
  chk_ctrl_write: assert property ($changed(conv_set_o) || $changed(read_set_o) |->
    $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 6'h0D) else $error("set field moved alone");
  chk_acq_codes: assert property ($past(nrst_i) |->
    acq_cycles_o inside {6'h0A, 6'h14, 6'h1E, 6'h28}) else $error("bad acquisition count");
  chk_start_cause: assert property (conv_start_o |->
    ($past(conv_trigger_n_i, 2) && !$past(conv_trigger_n_i)) || (!$past(cs_n_i, 2) && $past(cs_n_i)))
    else $error("start without edge");
  chk_start_single: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  chk_soft_block: assert property (soft_reset_o && $past(soft_reset_o) |-> !conv_start_o)
    else $error("start during soft reset");
  chk_pd_pin: assert property ($fell(power_down_pin_n_i) |-> ##[1:3] power_down_o)
    else $error("pin power-down missed");
  chk_fault_cause: assert property (|(fault_flags_o & ~$past(fault_flags_o)) |->
    $past(result_valid_i, 2)) else $error("fault without result");
  cover property (reg_rvalid_o);
  cover property (conv_start_o);
  cover property (|fault_flags_o);
endmodule // mcl_top_props
`default_nettype wire

// >>> tb/mcl_host.sv
// Purpose: Host model driving the register port.
// Assumes: Strobes launched 1 ns after the rising edge.
// Notes: Released lines show inverted values.
`timescale 1ns/1ps
`default_nettype none
module mcl_host (
  input wire logic ref_clk_i,
  input wire logic [11:0] rdata_i,
  input wire logic rvalid_i,
  output logic [5:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 6'h3F;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    // Termination is only requested with the longest acquisition time.
    if (a == 6'h0E && d[6:5] != 2'b11) d[3] = 1'b0;
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [11:0] q);
    int n;
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    q = 12'hXXX;
    for (n = 0; n < 8 && rvalid_i !== 1'b1; n++) @(posedge ref_clk_i) #1;
    if (rvalid_i === 1'b1) q = rdata_i;
  endtask
endmodule // mcl_host
`default_nettype wire

// >>> tb/mcl_top_tb.sv
// Purpose: Self-checking bench for the monitor control bank.
// Assumes: 25 MHz clock; host model owns the register port.
// Notes: Soft reset is issued as a set write then a clear write.
`timescale 1ns/1ps
`default_nettype none
module mcl_top_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [5:0] reg_addr_i, acq_cycles_o;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, conv_start_o, power_down_o;
  logic soft_reset_o, thermistor_termination_pin_o, alert_o;
  logic [11:0] reg_rdata_o, fault_flags_o, q;
  logic [1:0] conv_set_o, read_set_o;
  logic conv_trigger_n_i = 1'b1;
  logic cs_n_i = 1'b1;
  logic power_down_pin_n_i = 1'b1;
  logic result_valid_i = 1'b0;
  logic alert_chain_i = 1'b1;
  logic [3:0] result_chan_i = 4'h0;
  logic [11:0] result_data_i = 12'h000;
  int fails = 0;
  int checked = 0;
  int starts = 0;
  int s, code, n, hi, rise;
  logic prev;
  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (conv_start_o === 1'b1) starts <= starts + 1;
  mcl_top #(.SQ100_HALF_CYCLES(8), .SQ1K_HALF_CYCLES(4)) i_mcl_top (.*);
  mcl_host i_mcl_host (.ref_clk_i(ref_clk_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    i_mcl_host.wr(a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [11:0] e, input string nm);
    i_mcl_host.rd(a, q);
    chk(nm, e, q);
  endtask
  task automatic smp(input int ch, input int d);
    tick(1);
    result_valid_i = 1'b1;
    result_chan_i = 4'(ch);
    result_data_i = 12'(d);
    tick(1);
    result_valid_i = 1'b0;
    result_data_i = ~12'(d);
  endtask
  task automatic pin(input logic trig);
    if (trig) conv_trigger_n_i = 1'b0;
    else cs_n_i = 1'b0;
    tick(3);
    conv_trigger_n_i = 1'b1;
    cs_n_i = 1'b1;
    tick(3);
  endtask
  function automatic int lim(input int off, input int step);
    lim = (off + step * 128) * 4096 / 5000;
  endfunction
  initial begin
    #(40 * 20000);
    fails++;
    end_sim;
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    for (int i = 0; i < 6; i++) rdc(6'h0D + 6'(i), (i == 2 || i == 4) ? 12'h0FF : 12'h000, "rst");
    rdc(6'h20, 12'h000, "unmapped");
    for (int k = 0; k < 4; k++) begin
      w(6'h0D, {2'(k), 2'(k), 4'h0});
      w(6'h0E, {1'b0, 2'(k), 5'h00});
      tick(2);
      chk("conv_set", 12'(k), 12'(conv_set_o));
      chk("read_set", 12'(k), 12'(read_set_o));
      chk("acq", 12'(10 * k + 10), 12'(acq_cycles_o));
      rdc(6'h0D, {4'h0, 2'(k), 2'(k), 4'h0}, "ctrl_hi");
      rdc(6'h0E, {5'h00, 2'(k), 5'h00}, "ctrl_lo");
    end
    w(6'h0E, 8'h68);
    tick(2);
    chk("term", 12'h001, 12'(thermistor_termination_pin_o));
    w(6'h0D, 8'h00);
    w(6'h0E, 8'h00);
    $display("test ctrl done");
    s = starts;
    pin(1'b1);
    pin(1'b0);
    chk("pin_start", 12'h001, 12'(starts - s));
    w(6'h0D, 8'h08);
    s = starts;
    pin(1'b1);
    pin(1'b0);
    chk("cs_start", 12'h001, 12'(starts - s));
    w(6'h0E, 8'h80);
    tick(2);
    chk("soft_on", 12'h001, 12'(soft_reset_o));
    s = starts;
    pin(1'b0);
    chk("blocked", 12'h000, 12'(starts - s));
    w(6'h0E, 8'h00);
    tick(2);
    chk("soft_off", 12'h000, 12'(soft_reset_o));
    w(6'h0D, 8'h00);
    power_down_pin_n_i = 1'b0;
    tick(3);
    chk("pd_pin", 12'h001, 12'(power_down_o));
    power_down_pin_n_i = 1'b1;
    tick(3);
    chk("pd_off", 12'h000, 12'(power_down_o));
    w(6'h0D, 8'h01);
    tick(2);
    chk("pd_soft", 12'h001, 12'(power_down_o));
    w(6'h0D, 8'h00);
    $display("test start done");
    w(6'h13, 8'h40);
    for (int i = 0; i < 4; i++) begin
      code = (i < 2) ? lim(1000, 16) : lim(0, 19);
      n = (i < 2) ? 0 : 6;
      w(6'h0F + 6'(i), 8'h80);
      smp(n, code);
      tick(2);
      chk("at_limit", 12'h000, fault_flags_o);
      smp(n, (i % 2 == 0) ? code + 1 : code - 1);
      tick(2);
      chk("beyond", 12'h001 << n, fault_flags_o);
      chk("alert", 12'h001, 12'(alert_o));
      w(6'h0F + 6'(i), (i % 2 == 0) ? 8'hFF : 8'h00);
      smp(n, code);
      tick(2);
      chk("cleared", 12'h000, fault_flags_o);
    end
    $display("test limits done");
    code = lim(1000, 16);
    w(6'h0F, 8'h80);
    for (int k = 0; k < 4; k++) begin
      w(6'h0D, 8'(k << 1));
      for (int j = 0; j < (1 << k); j++) smp(0, code);
      tick(2);
      chk("avg_at", 12'h000, fault_flags_o);
      for (int j = 0; j < (1 << k); j++) smp(0, (j == 0) ? code + (1 << k) : code);
      tick(2);
      chk("avg_over", 12'h001, fault_flags_o);
    end
    $display("test average done");
    rdc(6'h00, 12'(code + 1), "res_volt");
    rdc(6'h06, 12'(lim(0, 19)), "res_temp");
    w(6'h0E, 8'h80);
    tick(2);
    chk("soft_clr", 12'h000, fault_flags_o);
    w(6'h0E, 8'h00);
    w(6'h0D, 8'h00);
    w(6'h13, 8'h44);
    smp(4, code + 1);
    tick(2);
    chk("excluded", 12'h000, fault_flags_o);
    w(6'h13, 8'h40);
    smp(4, code + 1);
    tick(2);
    chk("included", 12'h010, fault_flags_o);
    chk("alert_on", 12'h001, 12'(alert_o));
    for (int f = 0; f < 2; f++) begin
      w(6'h13, (f == 0) ? 8'h80 : 8'h90);
      tick(20);
      hi = 0;
      rise = 0;
      prev = alert_o;
      repeat (32) begin
        tick(1);
        hi = hi + int'(alert_o);
        rise = rise + int'(alert_o && !prev);
        prev = alert_o;
      end
      chk("sq_high", 12'h010, 12'(hi));
      chk("sq_rise", (f == 0) ? 12'h002 : 12'h004, 12'(rise));
    end
    w(6'h13, 8'hC0);
    tick(2);
    chk("pass_fault", 12'h000, 12'(alert_o));
    smp(4, code);
    tick(2);
    chk("pass_chain", 12'h001, 12'(alert_o));
    alert_chain_i = 1'b0;
    tick(2);
    chk("pass_low", 12'h000, 12'(alert_o));
    alert_chain_i = 1'b1;
    w(6'h13, 8'h00);
    tick(2);
    chk("alert_off", 12'h000, 12'(alert_o));
    rdc(6'h13, 12'h000, "alert_cfg");
    $display("test alert done");
    end_sim;
  end
endmodule // mcl_top_tb
bind mcl_top mcl_top_props i_mcl_top_props (.*);
`default_nettype wire
